// file: core/dma_irq_clear_combined_status.sv
// dma interrupt status-clear registers and combined summary word, ahb-lite slave
// assumes ahb signals and dma events are on CLOCK; transfer-done status comes from elsewhere
`timescale 1ns/1ns
module dma_irq_clear_combined_status (
    // clock and reset
    input wire logic CLOCK,
    input wire logic RESET_N,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [dma_irq_pkg::ADDR_W-1:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // dma core events, one-cycle pulses per channel and class
    input wire dma_irq_pkg::class_bits_t EVENT_SET,
    // transfer-done status held outside this block
    input wire logic [dma_irq_pkg::CHANNELS-1:0] TRANSFER_DONE_STATUS,
    // held status and summary back to the dma core
    output dma_irq_pkg::class_bits_t CLASS_STATUS,
    output logic [dma_irq_pkg::SUM_W-1:0] SUMMARY_STATUS
);

    localparam int CH = dma_irq_pkg::CHANNELS;

    // address phase capture
    logic wr_phase_reg;
    logic [dma_irq_pkg::ADDR_W-1:0] addr_phase_reg;
    logic [31:0] rdata_reg;
    logic [31:0] rdata_next;
    logic hreadyout_reg;
    logic hresp_reg;
    logic [dma_irq_pkg::SUM_W-1:0] summary_reg;

    wire access_ok = HSEL && HREADY && HTRANS[1];
    wire rd_access = access_ok && !HWRITE;
    wire wr_access = access_ok && HWRITE;

    dma_irq_pkg::class_bits_t status_bits;
    dma_irq_pkg::class_bits_t clear_bits;
    wire [dma_irq_pkg::SUM_W-1:0] summary_now;

    // per-channel clear mask for one class in the data phase of a write
    function automatic logic [CH-1:0] clear_mask(
        input logic wr,
        input logic [dma_irq_pkg::ADDR_W-1:0] addr,
        input logic [11:0] ofs,
        input logic [31:0] wdata
    );
        logic [CH-1:0] m;
        m = '0;
        if (wr && addr == ofs) begin
            m = wdata[CH-1:0];
        end
        return m;
    endfunction

    assign clear_bits.block = clear_mask(wr_phase_reg, addr_phase_reg,
        dma_irq_pkg::BLOCK_CLEAR_LO_OFS, HWDATA);
    assign clear_bits.source = clear_mask(wr_phase_reg, addr_phase_reg,
        dma_irq_pkg::SOURCE_CLEAR_LO_OFS, HWDATA);
    assign clear_bits.dest = clear_mask(wr_phase_reg, addr_phase_reg,
        dma_irq_pkg::DEST_CLEAR_LO_OFS, HWDATA);
    assign clear_bits.fault = clear_mask(wr_phase_reg, addr_phase_reg,
        dma_irq_pkg::FAULT_CLEAR_LO_OFS, HWDATA);
    // upper words decode to nothing, so writes there are dropped

    for (genvar k = 0; k < dma_irq_pkg::CLASSES; k++) begin : g_class
        irq_class_status #(
            .WIDTH(CH)
        ) u_status (
            .clock(CLOCK),
            .reset_n(RESET_N),
            .set(EVENT_SET[k*CH +: CH]),
            .clear(clear_bits[k*CH +: CH]),
            .status(status_bits[k*CH +: CH])
        );
    end

    assign summary_now[dma_irq_pkg::SUM_FAULT_BIT] = |status_bits.fault;
    assign summary_now[dma_irq_pkg::SUM_DEST_BIT] = |status_bits.dest;
    assign summary_now[dma_irq_pkg::SUM_SOURCE_BIT] = |status_bits.source;
    assign summary_now[dma_irq_pkg::SUM_BLOCK_BIT] = |status_bits.block;
    assign summary_now[dma_irq_pkg::SUM_TRANSFER_BIT] = |TRANSFER_DONE_STATUS;

    // read mux, only the summary word carries data
    // clear words, upper words and unmapped offsets all read zero
    always_comb begin
        rdata_next = dma_irq_pkg::WORD_RESET;
        if (rd_access && HADDR == dma_irq_pkg::SUMMARY_LO_OFS) begin
            rdata_next = {27'h0000000, summary_now};
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            wr_phase_reg <= 1'b0;
            addr_phase_reg <= '0;
        end else begin
            wr_phase_reg <= wr_access;
            addr_phase_reg <= HADDR;
        end
    end

    always_ff @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            rdata_reg <= dma_irq_pkg::WORD_RESET;
            summary_reg <= dma_irq_pkg::SUMMARY_RESET;
            hreadyout_reg <= 1'b1;
            hresp_reg <= dma_irq_pkg::HRESP_OKAY;
        end else begin
            rdata_reg <= rdata_next;
            summary_reg <= summary_now;
            hreadyout_reg <= 1'b1;
            hresp_reg <= dma_irq_pkg::HRESP_OKAY;
        end
    end

    assign HRDATA = rdata_reg;
    assign HREADYOUT = hreadyout_reg;
    assign HRESP = hresp_reg;
    assign CLASS_STATUS = status_bits;
    assign SUMMARY_STATUS = summary_reg;

    // checks
    sequence s_read_at(logic [11:0] ofs);
        rd_access && HADDR == ofs;
    endsequence

    sequence s_write_then_data(logic [11:0] ofs);
        (wr_access && HADDR == ofs) ##1 1'b1;
    endsequence

    property p_clear_takes(logic [11:0] ofs, int k);
        @(posedge CLOCK) disable iff (!RESET_N)
        s_write_then_data(ofs) |=>
            ((status_bits[k*CH +: CH] & $past(HWDATA[CH-1:0])
              & ~$past(EVENT_SET[k*CH +: CH])) == '0);
    endproperty

    AST_FAULT_SUMMARY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        1'b1 |=> SUMMARY_STATUS[dma_irq_pkg::SUM_FAULT_BIT] == $past(|status_bits.fault))
        else $error("fault summary differs from fault status");

    AST_DEST_SUMMARY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        1'b1 |=> SUMMARY_STATUS[dma_irq_pkg::SUM_DEST_BIT] == $past(|status_bits.dest))
        else $error("dest summary differs from dest status");

    AST_SOURCE_SUMMARY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        1'b1 |=> SUMMARY_STATUS[dma_irq_pkg::SUM_SOURCE_BIT] == $past(|status_bits.source))
        else $error("source summary differs from source status");

    AST_BLOCK_SUMMARY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        1'b1 |=> SUMMARY_STATUS[dma_irq_pkg::SUM_BLOCK_BIT] == $past(|status_bits.block))
        else $error("block summary differs from block status");

    AST_TRANSFER_SUMMARY: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        1'b1 |=> SUMMARY_STATUS[dma_irq_pkg::SUM_TRANSFER_BIT] == $past(|TRANSFER_DONE_STATUS))
        else $error("transfer summary differs from transfer status");

    AST_SUMMARY_READ: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        s_read_at(dma_irq_pkg::SUMMARY_LO_OFS) |=>
            (HRDATA[31:5] == 27'h0000000) && (HRDATA[4:0] == $past(summary_now)))
        else $error("summary read returned wrong data");

    AST_BLOCK_CLEAR: assert property (p_clear_takes(dma_irq_pkg::BLOCK_CLEAR_LO_OFS, 0))
        else $error("block clear did not clear");

    AST_SOURCE_CLEAR: assert property (p_clear_takes(dma_irq_pkg::SOURCE_CLEAR_LO_OFS, 1))
        else $error("source clear did not clear");

    AST_DEST_CLEAR: assert property (p_clear_takes(dma_irq_pkg::DEST_CLEAR_LO_OFS, 2))
        else $error("dest clear did not clear");

    AST_FAULT_CLEAR: assert property (p_clear_takes(dma_irq_pkg::FAULT_CLEAR_LO_OFS, 3))
        else $error("fault clear did not clear");

    AST_UPPER_INERT: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (rd_access && (HADDR == dma_irq_pkg::CLEAR_HI_OFS[0] || HADDR == dma_irq_pkg::CLEAR_HI_OFS[1]
         || HADDR == dma_irq_pkg::CLEAR_HI_OFS[2] || HADDR == dma_irq_pkg::CLEAR_HI_OFS[3]))
        |=> HRDATA == 32'h0000_0000)
        else $error("upper clear word did not read zero");

    AST_ZERO_KEEPS: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        1'b1 |=> ((status_bits & $past(status_bits & ~clear_bits)) == $past(status_bits & ~clear_bits)))
        else $error("status bit dropped without a clear");

    AST_CLEAR_READS_ZERO: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        (rd_access && (HADDR == dma_irq_pkg::CLEAR_LO_OFS[0] || HADDR == dma_irq_pkg::CLEAR_LO_OFS[1]
         || HADDR == dma_irq_pkg::CLEAR_LO_OFS[2] || HADDR == dma_irq_pkg::CLEAR_LO_OFS[3]))
        |=> HRDATA == 32'h0000_0000)
        else $error("clear word did not read zero");

    AST_IDLE_READ_ZERO: assert property (@(posedge CLOCK) disable iff (!RESET_N)
        !rd_access |=> HRDATA == 32'h0000_0000)
        else $error("read data not zero outside a read data phase");

endmodule

// file: core/dma_irq_pkg.sv
// constants and carrier types for the dma interrupt clear and summary block
// assumes a three-channel dma core and an ahb-lite register port on one clock
package dma_irq_pkg;

    // channels served by every interrupt class
    localparam int CHANNELS = 3;
    // interrupt classes held in this block: block, source, dest, fault
    localparam int CLASSES = 4;
    localparam int ADDR_W = 12;

    // status-clear words, low halves, index 0 block .. 3 fault
    localparam logic [3:0][11:0] CLEAR_LO_OFS = {12'h358, 12'h350, 12'h348, 12'h340};
    // reserved upper companion words
    localparam logic [3:0][11:0] CLEAR_HI_OFS = {12'h35C, 12'h354, 12'h34C, 12'h344};
    localparam logic [11:0] BLOCK_CLEAR_LO_OFS = 12'h340;
    localparam logic [11:0] SOURCE_CLEAR_LO_OFS = 12'h348;
    localparam logic [11:0] DEST_CLEAR_LO_OFS = 12'h350;
    localparam logic [11:0] FAULT_CLEAR_LO_OFS = 12'h358;
    localparam logic [11:0] SUMMARY_LO_OFS = 12'h360;

    // summary word layout
    localparam int SUM_TRANSFER_BIT = 0;
    localparam int SUM_BLOCK_BIT = 1;
    localparam int SUM_SOURCE_BIT = 2;
    localparam int SUM_DEST_BIT = 3;
    localparam int SUM_FAULT_BIT = 4;
    localparam int SUM_W = 5;

    // values after reset
    localparam logic [31:0] WORD_RESET = 32'h0000_0000;
    localparam logic [SUM_W-1:0] SUMMARY_RESET = 5'h00;
    localparam logic [CHANNELS-1:0] STATUS_RESET = 3'h0;

    // ahb-lite encodings
    localparam logic HRESP_OKAY = 1'b0;

    // one bit per channel for each class; packed so class k sits at [k*CHANNELS +: CHANNELS]
    typedef struct packed {
        logic [CHANNELS-1:0] fault;
        logic [CHANNELS-1:0] dest;
        logic [CHANNELS-1:0] source;
        logic [CHANNELS-1:0] block;
    } class_bits_t;

endpackage

// file: core/irq_class_status.sv
// one interrupt class: sticky per-channel status, set by the dma core, cleared by software
// assumes set and clear come from logic on the same clock
`timescale 1ns/1ns
module irq_class_status #(
    parameter int WIDTH = 3
) (
    // clock and reset
    input wire logic clock,
    input wire logic reset_n,
    // hardware events and software clears, one bit per channel
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clear,
    // held status
    output logic [WIDTH-1:0] status
);

    logic [WIDTH-1:0] status_reg;
    logic [WIDTH-1:0] status_next;

    if (WIDTH < 1 || WIDTH > 32) begin : g_bad_width
        $error("irq_class_status: WIDTH must be 1 to 32");
    end

    // one clears bit
    // a set in the same cycle as a clear wins, so no event is lost
    assign status_next = (status_reg & ~clear) | set;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            status_reg <= '0;
        end else begin
            status_reg <= status_next;
        end
    end

    assign status = status_reg;

    AST_SET_WINS: assert property (@(posedge clock) disable iff (!reset_n)
        (set != '0) |=> ((status_reg & $past(set)) == $past(set)))
        else $error("event lost against a clear");

endmodule

// file: tb/dma_irq_clear_combined_status_bench.sv
// self-checking bench for the dma interrupt clear and summary block
// assumes the design's ahb-lite port, event inputs and one 100 MHz clock
`timescale 1ns/1ns
module dma_irq_clear_combined_status_bench;
    logic CLOCK = 1'b0;
    logic RESET_N = 1'b0;
    logic HSEL = 1'b0;
    logic [11:0] HADDR = 12'h000;
    logic [1:0] HTRANS = 2'h0;
    logic HWRITE = 1'b0;
    logic [2:0] HSIZE = 3'h2;
    logic [31:0] HWDATA = 32'h0000_0000;
    logic HREADY = 1'b1;
    dma_irq_pkg::class_bits_t EVENT_SET = 12'h000;
    logic [2:0] TRANSFER_DONE_STATUS = 3'h0;
    wire [31:0] HRDATA;
    wire HREADYOUT;
    wire HRESP;
    dma_irq_pkg::class_bits_t CLASS_STATUS;
    logic [4:0] SUMMARY_STATUS;
    dma_irq_pkg::class_bits_t exp_st;
    logic [4:0] exp_sum;
    logic dp_wr;
    logic [11:0] dp_addr;
    int err_count = 0;
    int compares = 0;
    dma_irq_clear_combined_status dma_irq_clear_combined_status_i (
        .CLOCK(CLOCK), .RESET_N(RESET_N), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
        .HREADYOUT(HREADYOUT), .HRESP(HRESP), .EVENT_SET(EVENT_SET),
        .TRANSFER_DONE_STATUS(TRANSFER_DONE_STATUS), .CLASS_STATUS(CLASS_STATUS),
        .SUMMARY_STATUS(SUMMARY_STATUS)
    );
    always #5 CLOCK = ~CLOCK;
    function automatic logic [11:0] clr_vec(input logic wr, input logic [11:0] a,
                                            input logic [31:0] d);
        if (!wr) return 12'h000;
        case (a)
            12'h340: return {9'h000, d[2:0]};
            12'h348: return {6'h00, d[2:0], 3'h0};
            12'h350: return {3'h0, d[2:0], 6'h00};
            12'h358: return {d[2:0], 9'h000};
            default: return 12'h000;
        endcase
    endfunction
    function automatic logic [4:0] sum_of(input dma_irq_pkg::class_bits_t s, input logic [2:0] t);
        return {|s.fault, |s.dest, |s.source, |s.block, |t};
    endfunction
    // model: write-one clears in the data phase, a new event wins over a clear
    always @(posedge CLOCK or negedge RESET_N) begin
        if (!RESET_N) begin
            exp_st <= 12'h000;
            exp_sum <= 5'h00;
            dp_wr <= 1'b0;
            dp_addr <= 12'h000;
        end else begin
            exp_st <= (exp_st & ~clr_vec(dp_wr, dp_addr, HWDATA)) | EVENT_SET;
            exp_sum <= sum_of(exp_st, TRANSFER_DONE_STATUS);
            dp_wr <= HSEL && HREADY && HTRANS[1] && HWRITE;
            dp_addr <= HADDR;
        end
    end
    task automatic check(input logic ok, input string msg);
        compares++;
        if (!ok) begin
            err_count++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    always @(negedge CLOCK) begin
        check(CLASS_STATUS === exp_st, "class status");
        check(SUMMARY_STATUS === exp_sum, "summary status");
        check(HREADYOUT === 1'b1 && HRESP === 1'b0, "bus response");
    end
    // one non-pipelined transfer; reads are compared in the data phase
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        logic [31:0] exp;
        @(posedge CLOCK);
        HSEL <= 1'b1;
        HTRANS <= 2'h2;
        HWRITE <= wr;
        HADDR <= a;
        @(posedge CLOCK);
        HTRANS <= 2'h0;
        HWDATA <= d;
        @(negedge CLOCK);
        exp = (a == 12'h360) ? {27'h0, sum_of(exp_st, TRANSFER_DONE_STATUS)} : 32'h0;
        if (!wr) check(HRDATA === exp, "read data");
        @(negedge CLOCK);
        if (!wr) check(HRDATA === 32'h0, "read data after data phase");
    endtask
    // quiet the events first so the read sees settled status
    task automatic rd(input logic [11:0] a);
        @(posedge CLOCK);
        EVENT_SET <= 12'h000;
        xfer(1'b0, a, 32'h0);
    endtask
    task tally_and_finish;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #100000;
        err_count++;
        tally_and_finish;
    end
    initial begin
        logic [11:0] offs [11];
        offs = '{12'h340, 12'h344, 12'h348, 12'h34C, 12'h350, 12'h354, 12'h358, 12'h35C,
                 12'h360, 12'h364, 12'h000};
        void'($urandom(41698));
        repeat (5) @(posedge CLOCK);
        RESET_N <= 1'b1;
        for (int k = 0; k < 11; k++) rd(offs[k]);
        for (int c = 0; c < 4; c++) begin
            @(posedge CLOCK);
            EVENT_SET <= 12'hFFF;
            xfer(1'b1, dma_irq_pkg::CLEAR_HI_OFS[c], 32'hFFFF_FFFF);
            xfer(1'b1, dma_irq_pkg::SUMMARY_LO_OFS, 32'hFFFF_FFFF);
            rd(dma_irq_pkg::CLEAR_LO_OFS[c]);
            rd(dma_irq_pkg::SUMMARY_LO_OFS);
            xfer(1'b1, dma_irq_pkg::CLEAR_LO_OFS[c], 32'hFFFF_FFF5);
            rd(dma_irq_pkg::SUMMARY_LO_OFS);
            xfer(1'b1, dma_irq_pkg::CLEAR_LO_OFS[c], 32'h0000_0002);
            rd(dma_irq_pkg::SUMMARY_LO_OFS);
        end
        for (int i = 0; i < 300; i++) begin
            @(posedge CLOCK);
            EVENT_SET <= 12'($urandom & $urandom);
            TRANSFER_DONE_STATUS <= 3'($urandom);
            case ($urandom % 4)
                0: xfer(1'b1, dma_irq_pkg::CLEAR_LO_OFS[$urandom % 4], $urandom);
                1: rd(dma_irq_pkg::SUMMARY_LO_OFS);
                default: ;
            endcase
            if (i == 150) begin
                @(posedge CLOCK);
                RESET_N <= 1'b0;
                @(posedge CLOCK);
                @(posedge CLOCK);
                RESET_N <= 1'b1;
            end
        end
        repeat (3) @(posedge CLOCK);
        tally_and_finish;
    end
endmodule
